// File: usd_pkg.sv
// Overview of operation
// - Sixteen consecutive word slots all alias the receive buffer and transmit holding.
// - Reading the data field returns the received byte from serial or infrared input.
// - Read data is meaningful only while the data-ready flag is set.
// - FIFOs disabled: a new character overwrites an unread buffer and flags overrun.
// - FIFOs enabled: a read returns the entry at the head of the receive FIFO.
// - Receive FIFO full: keep contents, drop the new character, flag overrun.
// - A write supplies a character for the serial or active-low infrared output.
// - FIFOs disabled: one write with the empty flag set clears that flag.
// - FIFOs disabled: further writes before the flag sets again overwrite the character.
// - FIFOs enabled: up to sixteen characters are accepted before the FIFO is full.
// - A write while the transmit FIFO is full is discarded, contents unchanged.
package usd_pkg;

  localparam logic [31:0] SHADOW_BASE  = 32'h5000_1130;
  localparam logic [31:0] SHADOW_SLOT7 = 32'h5000_114C;
  localparam int          SHADOW_SLOTS = 16;
  localparam logic [31:0] SHADOW_LAST  = 32'h5000_116C;
  localparam logic [31:0] FIFO_CTRL_OFFS   = 32'h5000_1180;
  localparam logic [31:0] LINE_STATUS_OFFS = 32'h5000_1184;
  localparam logic [31:0] MODE_CTRL_OFFS   = 32'h5000_1188;

  localparam int RX_FIFO_DEPTH = 8;
  localparam int TX_FIFO_DEPTH = 16;
  localparam int CHAR_WIDTH    = 8;

  localparam int FIFO_ENABLE_BIT = 0;
  localparam int INFRARED_BIT    = 0;

  localparam logic       FIFO_ENABLE_RESET = 1'b0;
  localparam logic       INFRARED_RESET    = 1'b0;
  localparam logic [7:0] CHAR_RESET        = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Line status byte; field order gives the bit positions (data ready is bit 0, empty is bit 5).
  typedef struct packed {
    logic rsvd7;
    logic rsvd6;
    logic tx_holding_empty_flag;
    logic tx_full;
    logic rx_full;
    logic rsvd2;
    logic overrun;
    logic rx_data_ready_flag;
  } usd_line_status_s;

  typedef struct packed {
    logic       infrared;
    logic [7:0] data;
  } usd_char_s;

endpackage : usd_pkg

// File: usd_fifo.sv
`timescale 1ns/1ps
module usd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : usd_fifo

// File: usd_hold_buf.sv
`timescale 1ns/1ps
module usd_hold_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Load side; a load while full overwrites the held word
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_data,
  // Take side
  input  wire logic             take,
  output logic                  full,
  output logic [WIDTH-1:0]      data
);

  always_ff @(posedge mclk) begin
    if (rst) begin
      data <= '0;
    end else if (load) begin
      data <= load_data;
    end
  end

  // A load in the same cycle as a take leaves the buffer full with the new word.
  always_ff @(posedge mclk) begin
    if (rst || flush) begin
      full <= 1'b0;
    end else if (load) begin
      full <= 1'b1;
    end else if (take) begin
      full <= 1'b0;
    end
  end

endmodule : usd_hold_buf

// File: usd_shadow_port.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module usd_shadow_port (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Received characters from the serial deserialiser
  input  wire logic        sin_valid,
  input  wire logic [7:0]  sin_data,
  // Received characters from the infrared decoder
  input  wire logic        sir_in_valid,
  input  wire logic [7:0]  sir_in_data,
  output logic             rx_ready,
  // Characters for the serial transmitter
  output logic             sout_valid,
  output logic [7:0]       sout_data,
  input  wire logic        sout_ready,
  // Characters for the infrared encoder, inverted for the active-low output
  output logic             sir_out_valid,
  output logic [7:0]       sir_out_data_n,
  input  wire logic        sir_out_ready,
  // Line status levels
  output logic             rx_data_ready_flag,
  output logic             tx_holding_empty_flag,
  output logic             overrun_flag
);

  import usd_pkg::*;

  // Control registers.
  logic             fifo_enable;
  logic             infrared;
  logic             overrun;

  // Write channel state.
  logic             aw_held;
  logic [31:0]      aw_addr;
  logic             w_held;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             wr_fire;

  // Read channel state.
  logic             rd_fire;
  logic [31:0]      next_rdata;
  logic [1:0]       next_rresp;

  // Decode.
  logic             wr_shadow;
  logic             rd_shadow;
  logic             wr_fifo_ctrl;
  logic             wr_mode_ctrl;
  logic             rd_status;
  logic             wr_mapped;
  logic             rd_mapped;
  logic             mode_change;

  // Receive path.
  logic             rx_event;
  logic [7:0]       rx_char;
  logic             rx_fifo_in_ready;
  logic             rx_fifo_valid;
  logic [7:0]       rx_fifo_data;
  logic             rx_fifo_pop;
  logic             rx_hold_full;
  logic [7:0]       rx_hold_data;
  logic             rx_hold_take;
  logic             rx_lost;
  logic [7:0]       rx_head;

  // Transmit path.
  logic             tx_write;
  logic             tx_fifo_in_ready;
  logic             tx_fifo_valid;
  usd_char_s        tx_fifo_data;
  logic             tx_hold_full;
  usd_char_s        tx_hold_data;
  logic             tx_drain_ready;
  logic             tx_src_valid;
  usd_char_s        tx_src;
  usd_char_s        tx_in;

  usd_line_status_s status;

  function automatic logic in_shadow(input logic [31:0] addr);
    in_shadow = (addr >= SHADOW_BASE) && (addr <= SHADOW_LAST) && (addr[1:0] == 2'h0);
  endfunction : in_shadow

  // Address and data are taken independently and held until both are present.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  assign wr_shadow    = wr_fire && in_shadow(aw_addr);
  assign wr_fifo_ctrl = wr_fire && (aw_addr == FIFO_CTRL_OFFS);
  assign wr_mode_ctrl = wr_fire && (aw_addr == MODE_CTRL_OFFS);
  assign wr_mapped    = in_shadow(aw_addr) || (aw_addr == FIFO_CTRL_OFFS)
                     || (aw_addr == MODE_CTRL_OFFS) || (aw_addr == LINE_STATUS_OFFS);

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the low byte lane carries control bits; other lanes are ignored.
  always_ff @(posedge mclk) begin
    if (rst) begin
      fifo_enable <= FIFO_ENABLE_RESET;
    end else if (wr_fifo_ctrl && w_strb[0]) begin
      fifo_enable <= w_data[FIFO_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      infrared <= INFRARED_RESET;
    end else if (wr_mode_ctrl && w_strb[0]) begin
      infrared <= w_data[INFRARED_BIT];
    end
  end

  // Switching FIFO mode empties every buffer so no stale character crosses modes.
  assign mode_change = wr_fifo_ctrl && w_strb[0] && (w_data[FIFO_ENABLE_BIT] != fifo_enable);

  // Read channel: one read at a time, answered on the edge after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_shadow     = rd_fire && in_shadow(s_axi_araddr);
  assign rd_status     = rd_fire && (s_axi_araddr == LINE_STATUS_OFFS);
  assign rd_mapped     = in_shadow(s_axi_araddr) || (s_axi_araddr == FIFO_CTRL_OFFS)
                      || (s_axi_araddr == MODE_CTRL_OFFS) || (s_axi_araddr == LINE_STATUS_OFFS);

  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (in_shadow(s_axi_araddr)) begin
      next_rdata = {24'h00_0000, rx_head};
    end else if (s_axi_araddr == FIFO_CTRL_OFFS) begin
      next_rdata = {31'h0000_0000, fifo_enable};
    end else if (s_axi_araddr == MODE_CTRL_OFFS) begin
      next_rdata = {31'h0000_0000, infrared};
    end else if (s_axi_araddr == LINE_STATUS_OFFS) begin
      next_rdata = {24'h00_0000, status};
    end else if (!rd_mapped) begin
      next_rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Receive source follows the mode; the other source is ignored.
  assign rx_event = infrared ? sir_in_valid : sin_valid;
  assign rx_char  = infrared ? sir_in_data : sin_data;

  // A shadow read consumes the character only when one is there to consume.
  assign rx_fifo_pop  = rd_shadow && fifo_enable && rx_fifo_valid;
  assign rx_hold_take = rd_shadow && !fifo_enable && rx_hold_full;
  assign rx_head      = fifo_enable ? rx_fifo_data : rx_hold_data;

  usd_fifo #(
    .WIDTH (CHAR_WIDTH),
    .DEPTH (RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (mode_change),
    .in_valid  (rx_event && fifo_enable),
    .in_ready  (rx_fifo_in_ready),
    .in_data   (rx_char),
    .out_valid (rx_fifo_valid),
    .out_ready (rx_fifo_pop),
    .out_data  (rx_fifo_data)
  );

  usd_hold_buf #(
    .WIDTH (CHAR_WIDTH)
  ) u_rx_hold (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (mode_change),
    .load      (rx_event && !fifo_enable),
    .load_data (rx_char),
    .take      (rx_hold_take),
    .full      (rx_hold_full),
    .data      (rx_hold_data)
  );

  // Serial input cannot be stalled, so ready is advisory; a full buffer means loss.
  assign rx_ready = fifo_enable ? rx_fifo_in_ready : 1'b1;

  // Loss: overwrite of an unread buffer, or arrival at a full FIFO, even one that is
  // popping in the same cycle (the FIFO refuses the push, so contents stay).
  assign rx_lost = rx_event && (fifo_enable ? !rx_fifo_in_ready
                                            : (rx_hold_full && !rx_hold_take));

  // Reading status clears overrun, but a loss in the same cycle keeps it set.
  always_ff @(posedge mclk) begin
    if (rst || mode_change) begin
      overrun <= 1'b0;
    end else begin
      overrun <= (overrun && !rd_status) || rx_lost;
    end
  end

  // Transmit: a shadow write with the low lane enabled queues one character.
  assign tx_write = wr_shadow && w_strb[0];
  assign tx_in    = '{infrared: infrared, data: w_data[7:0]};

  usd_fifo #(
    .WIDTH ($bits(usd_char_s)),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (mode_change),
    .in_valid  (tx_write && fifo_enable),
    .in_ready  (tx_fifo_in_ready),
    .in_data   (tx_in),
    .out_valid (tx_fifo_valid),
    .out_ready (tx_drain_ready && fifo_enable),
    .out_data  (tx_fifo_data)
  );

  // In single-buffer mode a write before the character leaves replaces it.
  usd_hold_buf #(
    .WIDTH ($bits(usd_char_s))
  ) u_tx_hold (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (mode_change),
    .load      (tx_write && !fifo_enable),
    .load_data (tx_in),
    .take      (tx_drain_ready && !fifo_enable),
    .full      (tx_hold_full),
    .data      (tx_hold_data)
  );

  assign tx_src_valid = fifo_enable ? tx_fifo_valid : tx_hold_full;
  assign tx_src       = fifo_enable ? tx_fifo_data : tx_hold_data;

  // Each character goes to the output chosen when it was written.
  assign tx_drain_ready = tx_src_valid && (tx_src.infrared ? sir_out_ready : sout_ready);
  assign sout_valid     = tx_src_valid && !tx_src.infrared;
  assign sir_out_valid  = tx_src_valid && tx_src.infrared;
  assign sout_data      = tx_src.data;
  assign sir_out_data_n = ~tx_src.data;

  // A write that the software makes with the empty flag clear is still handled:
  // it overwrites in single-buffer mode and is dropped by a full FIFO.
  always_comb begin
    status                       = '0;
    status.rx_data_ready_flag    = fifo_enable ? rx_fifo_valid : rx_hold_full;
    status.overrun               = overrun;
    status.rx_full               = fifo_enable && !rx_fifo_in_ready;
    status.tx_full               = fifo_enable && !tx_fifo_in_ready;
    status.tx_holding_empty_flag = fifo_enable ? !tx_fifo_valid : !tx_hold_full;
  end

  assign rx_data_ready_flag    = status.rx_data_ready_flag;
  assign tx_holding_empty_flag = status.tx_holding_empty_flag;
  assign overrun_flag          = overrun;

endmodule : usd_shadow_port

// File: usd_shadow_port_chk.sv
`timescale 1ns/1ps
module usd_shadow_port_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Line side
  input wire logic        sin_valid,
  input wire logic        sir_in_valid,
  input wire logic        sout_valid,
  input wire logic        sir_out_valid,
  // Status levels
  input wire logic        rx_data_ready_flag,
  input wire logic        tx_holding_empty_flag,
  input wire logic        overrun_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  rst_flags_a: assert property (
    $fell(rst) |-> !rx_data_ready_flag && tx_holding_empty_flag && !overrun_flag)
    else $error("flags wrong after reset");
  dr_cause_a: assert property (
    $rose(rx_data_ready_flag) |-> $past(sin_valid || sir_in_valid))
    else $error("data ready rose without an arrival");
  ovr_cause_a: assert property (
    $rose(overrun_flag) |-> $past(sin_valid || sir_in_valid))
    else $error("overrun rose without an arrival");
  tx_pend_a: assert property (
    (sout_valid || sir_out_valid) |-> !tx_holding_empty_flag)
    else $error("empty flag high with a character pending");
  one_out_a: assert property (
    !(sout_valid && sir_out_valid))
    else $error("both outputs offered at once");
  wr_resp_a: assert property (
    !s_axi_bvalid && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rd_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule : usd_shadow_port_chk

bind usd_shadow_port usd_shadow_port_chk usd_shadow_port_chk_inst (.mclk, .rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .sin_valid, .sir_in_valid, .sout_valid, .sir_out_valid,
  .rx_data_ready_flag, .tx_holding_empty_flag, .overrun_flag);

// File: usd_line_peer.sv
`timescale 1ns/1ps
module usd_line_peer (
  // Clock and pacing
  input wire logic        mclk,
  input wire logic        stall,
  // Characters towards the block
  output logic            sin_valid,
  output logic [7:0]      sin_data,
  output logic            sir_in_valid,
  output logic [7:0]      sir_in_data,
  // Characters from the block
  input wire logic        sout_valid,
  input wire logic [7:0]  sout_data,
  output logic            sout_ready,
  input wire logic        sir_out_valid,
  input wire logic [7:0]  sir_out_data_n,
  output logic            sir_out_ready
);
  logic [7:0] got[$];

  initial begin
    sin_valid = 1'b0;
    sir_in_valid = 1'b0;
    sin_data = 8'h00;
    sir_in_data = 8'h00;
  end

  assign sout_ready = !stall;
  assign sir_out_ready = !stall;

  // The infrared line is active low, so its character arrives inverted.
  always @(posedge mclk) begin
    if (sout_valid && sout_ready) got.push_back(sout_data);
    if (sir_out_valid && sir_out_ready) got.push_back(~sir_out_data_n);
  end

  // Data lines show the inverse afterwards so a stale value is never mistaken for a new one.
  task automatic send(input logic ir, input logic [7:0] d);
    @(posedge mclk);
    if (ir) sir_in_valid <= 1'b1;
    else sin_valid <= 1'b1;
    sin_data <= d;
    sir_in_data <= d;
    @(posedge mclk);
    sin_valid <= 1'b0;
    sir_in_valid <= 1'b0;
    sin_data <= ~d;
    sir_in_data <= ~d;
  endtask : send
endmodule : usd_line_peer

// File: uart_shadow_data_port_tb.sv
`timescale 1ns/1ps
module uart_shadow_data_port_tb;
  import usd_pkg::*;
  logic        mclk, rst, stall, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, sin_valid, sir_in_valid, rx_ready, sout_valid, sout_ready;
  logic        sir_out_valid, sir_out_ready, rx_data_ready_flag, tx_holding_empty_flag;
  logic        overrun_flag;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  sin_data, sir_in_data, sout_data, sir_out_data_n;
  int          num_errors, compares, cyc;

  usd_shadow_port usd_shadow_port_inst (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sin_valid, .sin_data,
    .sir_in_valid, .sir_in_data, .rx_ready, .sout_valid, .sout_data, .sout_ready,
    .sir_out_valid, .sir_out_data_n, .sir_out_ready, .rx_data_ready_flag,
    .tx_holding_empty_flag, .overrun_flag);

  usd_line_peer usd_line_peer_inst (.mclk, .stall, .sin_valid, .sin_data, .sir_in_valid,
    .sir_in_data, .sout_valid, .sout_data, .sout_ready, .sir_out_valid, .sir_out_data_n,
    .sir_out_ready);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic wrc(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wrc

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, d, exp);
    chk("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rdc

  task automatic t_reset;
    rdc("status", LINE_STATUS_OFFS, 32'h0000_0020);
    rdc("fifo ctrl", FIFO_CTRL_OFFS, 32'h0);
    rdc("mode", MODE_CTRL_OFFS, 32'h0);
    rdc("slot7", SHADOW_SLOT7, 32'h0);
  endtask : t_reset

  task automatic t_single_rx;
    logic [31:0] d;
    logic [1:0]  r;
    usd_line_peer_inst.send(1'b0, 8'h11);
    usd_line_peer_inst.send(1'b0, 8'h22);
    @(posedge mclk);
    chk("data ready", {31'h0, rx_data_ready_flag}, 32'h1);
    chk("overrun", {31'h0, overrun_flag}, 32'h1);
    rd(LINE_STATUS_OFFS, d, r);
    chk("status", d & 32'h23, 32'h23);
    @(posedge mclk);
    chk("overrun clear", {31'h0, overrun_flag}, 32'h0);
    rdc("slot7", SHADOW_SLOT7, 32'h22);
    @(posedge mclk);
    chk("data ready", {31'h0, rx_data_ready_flag}, 32'h0);
  endtask : t_single_rx

  task automatic t_alias;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < SHADOW_SLOTS; i++) begin
      usd_line_peer_inst.send(1'b0, 8'h40 + 8'(i));
      rdc("slot", SHADOW_BASE + 32'(4 * i), 32'h40 + 32'(i));
    end
    rd(32'h5000_1190, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped data", d, 32'h0);
    wrc(MODE_CTRL_OFFS, 32'h1);
    usd_line_peer_inst.send(1'b1, 8'h3C);
    usd_line_peer_inst.send(1'b0, 8'h77);
    rdc("infrared rx", SHADOW_LAST, 32'h3C);
    @(posedge mclk);
    chk("data ready", {31'h0, rx_data_ready_flag}, 32'h0);
    wrc(MODE_CTRL_OFFS, 32'h0);
  endtask : t_alias

  task automatic t_single_tx;
    usd_line_peer_inst.got.delete();
    stall <= 1'b1;
    chk("empty", {31'h0, tx_holding_empty_flag}, 32'h1);
    wrc(SHADOW_BASE, 32'h41);
    chk("empty", {31'h0, tx_holding_empty_flag}, 32'h0);
    wrc(SHADOW_LAST, 32'h42);
    stall <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("tx count", 32'(usd_line_peer_inst.got.size()), 32'h1);
    chk("tx char", {24'h0, usd_line_peer_inst.got[0]}, 32'h42);
    chk("empty", {31'h0, tx_holding_empty_flag}, 32'h1);
    wrc(MODE_CTRL_OFFS, 32'h1);
    wrc(SHADOW_SLOT7, 32'h5A);
    repeat (4) @(posedge mclk);
    chk("infrared tx", {24'h0, usd_line_peer_inst.got[1]}, 32'h5A);
    wrc(MODE_CTRL_OFFS, 32'h0);
  endtask : t_single_tx

  task automatic t_fifo_rx;
    wrc(FIFO_CTRL_OFFS, 32'h1);
    for (int i = 0; i < RX_FIFO_DEPTH + 1; i++) usd_line_peer_inst.send(1'b0, 8'hA0 + 8'(i));
    @(posedge mclk);
    chk("overrun", {31'h0, overrun_flag}, 32'h1);
    chk("rx ready", {31'h0, rx_ready}, 32'h0);
    rdc("status", LINE_STATUS_OFFS, 32'h0000_002B);
    for (int i = 0; i < RX_FIFO_DEPTH; i++) begin
      rdc("rx fifo", SHADOW_BASE + 32'(4 * i), 32'hA0 + 32'(i));
    end
    @(posedge mclk);
    chk("data ready", {31'h0, rx_data_ready_flag}, 32'h0);
    chk("rx ready", {31'h0, rx_ready}, 32'h1);
  endtask : t_fifo_rx

  task automatic t_fifo_tx;
    usd_line_peer_inst.got.delete();
    stall <= 1'b1;
    for (int i = 0; i <= TX_FIFO_DEPTH; i++) wrc(SHADOW_BASE, 32'hC0 + 32'(i));
    chk("empty", {31'h0, tx_holding_empty_flag}, 32'h0);
    rdc("status", LINE_STATUS_OFFS, 32'h0000_0010);
    stall <= 1'b0;
    repeat (TX_FIFO_DEPTH + 8) @(posedge mclk);
    chk("tx count", 32'(usd_line_peer_inst.got.size()), 32'(TX_FIFO_DEPTH));
    for (int i = 0; i < TX_FIFO_DEPTH; i++) begin
      chk("tx fifo", {24'h0, usd_line_peer_inst.got[i]}, 32'hC0 + 32'(i));
    end
    wrc(FIFO_CTRL_OFFS, 32'h0);
  endtask : t_fifo_tx

  // A hang would otherwise leave the run without a verdict.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    num_errors = 0;
    compares = 0;
    cyc = 0;
    rst = 1'b1;
    stall = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_single_rx();
    t_alias();
    t_single_tx();
    t_fifo_rx();
    t_fifo_tx();
    end_sim();
  end
endmodule : uart_shadow_data_port_tb
